/* design/edge_sync.sv */
module edge_sync
  import pcsu_pkg::*;
(
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic rising_i, // 1 selects rising edge
  input wire logic pin_i, // Asynchronous pin
  output logic edge_o // One-cycle valid edge pulse
);
  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  // Change counts once second and third stage agree
  always_comb
  begin
    st_nxt = st_r;
    edge_o = 1'b0;
    if (ce_i)
    begin
      st_nxt.s1 = pin_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3 && st_r.s3 != st_r.lvl)
      begin
        st_nxt.lvl = st_r.s3;
        edge_o = (st_r.s3 == rising_i);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule

/* design/pc_stack_context_unit.sv */
// What this block does
// - Computed call loads low byte, latch upper
// - Accumulator jump: PC+1 plus unsigned accumulator
// - Immediate jump: PC+1 plus signed operand
// - Relative sum carries into upper bits
// - Sixteen-entry fifteen-bit private return stack
// - Calls and interrupt entry push PC+1
// - Returns and interrupt exit pop PC
// - Push and pop leave latch unchanged
// - Fault-reset off makes stack circular
// - Overrun/underrun flags set regardless of reset
// - Top window reads/writes entry at index
// - Stack index is five bits wide
// - Index increments on push, decrements on pop except an underflow with fault reset on, which holds it
// - Interrupt entry copies core registers to shadows
// - Interrupt exit restores registers from shadows
// - Shadows software accessible at AHB offsets 0x20 to 0x3C
// - Valid pin edge sets flag, may vector
module pc_stack_context_unit
  import pcsu_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
)
(
  input wire logic clk_i, // Core clock, 100 MHz
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic ce_i, // Clock enable, freezes all state
  input wire flow_op_type op_i, // Decoder flow operation, one cycle
  input wire logic [7:0] operand_i, // Signed relative offset for immediate jump
  input wire logic [PC_W-1:0] abs_target_i, // Call/goto absolute target
  input wire logic [7:0] acc_i, // Live accumulator
  input wire logic [7:0] status_i, // Live status register
  input wire logic [7:0] bank_i, // Live bank select
  input wire logic [15:0] ptr0_i, // Live indirect pointer 0
  input wire logic [15:0] ptr1_i, // Live indirect pointer 1
  input wire logic [6:0] latch_i, // Live upper address latch
  input wire logic irq_pin_i, // External interrupt pin
  input wire logic irq_rising_i, // Edge polarity select
  input wire logic global_irq_enable_i, // Global interrupt enable
  input wire logic ext_irq_enable_i, // External interrupt enable
  input wire logic irq_flag_clr_i, // Clear external interrupt flag
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hsel, // AHB select
  input wire logic hready, // AHB ready in
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB ready out
  output logic hresp, // AHB response
  output logic [PC_W-1:0] pc_o, // Program counter
  output logic irq_taken_o, // Interrupt vectoring this cycle
  output logic irq_flag_o, // External interrupt flag
  output logic restore_o, // Shadow restore strobe
  output logic [7:0] restore_acc_o, // Restored accumulator
  output logic [7:0] restore_status_o, // Restored status (no expiry/sleep)
  output logic [7:0] restore_bank_o, // Restored bank select
  output logic [15:0] restore_ptr0_o, // Restored pointer 0
  output logic [15:0] restore_ptr1_o, // Restored pointer 1
  output logic [6:0] restore_latch_o, // Restored latch
  output logic stack_overrun_flag_o, // Overflow seen
  output logic stack_underrun_flag_o, // Underflow seen
  output logic stack_fault_reset_o // Request device reset on fault
);
  localparam logic [SP_W-1:0] TOP_IDX = SP_W'(DEPTH - 1);
  localparam logic [SP_W-1:0] ONE_IDX = 5'h01;

  typedef struct packed
  {
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] idx;
    logic ovf;
    logic unf;
    logic fault_rst_cfg;
    logic irq_flag;
    logic in_irq;
    logic restore;
    logic fault_req;
    logic dph;
    logic dwr;
    logic [7:0] daddr;
    logic [31:0] rdata;
  } core_state_type;

  core_state_type st_r;
  core_state_type st_nxt;
  logic [DEPTH-1:0][PC_W-1:0] stack_r;
  logic [DEPTH-1:0][PC_W-1:0] stack_nxt;
  logic pin_edge;
  logic [8*SH_COUNT-1:0] shadow;
  logic sh_we;
  logic [2:0] sh_sel;
  logic irq_go;
  logic [PC_W-1:0] pc_inc;
  logic [3:0] slot;
  logic [SP_W-1:0] idx_inc;

  edge_sync u_edge
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .rising_i(irq_rising_i),
    .pin_i(irq_pin_i),
    .edge_o(pin_edge)
  );

  shadow_bank u_shadow
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .save_i(irq_go),
    .live_i({latch_i[6:0] & 8'h7F, ptr1_i[15:8], ptr1_i[7:0], ptr0_i[15:8], ptr0_i[7:0],
      bank_i, status_i, acc_i}),
    .sw_we_i(sh_we),
    .sw_sel_i(sh_sel),
    .sw_data_i(hwdata[7:0]),
    .copy_o(shadow)
  );

  // Vectoring needs flag plus both enables, not inside a handler
  assign irq_go = st_r.irq_flag && global_irq_enable_i && ext_irq_enable_i
    && !st_r.in_irq && ce_i;
  assign pc_inc = st_r.pc + 15'h0001;
  assign idx_inc = st_r.idx + ONE_IDX;
  assign slot = st_r.idx[3:0];
  assign sh_we = st_r.dph && st_r.dwr && st_r.daddr >= OFS_SHADOW_ACC
    && st_r.daddr <= OFS_SHADOW_LATCH;
  assign sh_sel = 3'(st_r.daddr[7:2] - OFS_SHADOW_ACC[7:2]);

  // Flow, stack, flags and bus slave in one next-state process
  always_comb
  begin
    logic push;
    logic pop;
    logic [PC_W-1:0] target;
    logic [3:0] wslot;
    push = 1'b0;
    pop = 1'b0;
    target = pc_inc;
    wslot = 4'h0;
    st_nxt = st_r;
    stack_nxt = stack_r;
    if (ce_i)
    begin
      st_nxt.restore = 1'b0;
      st_nxt.fault_req = 1'b0;
      // Pin edge sets the flag; set wins over clear
      if (irq_flag_clr_i)
        st_nxt.irq_flag = 1'b0;
      if (pin_edge)
        st_nxt.irq_flag = 1'b1;
      if (irq_go)
      begin
        push = 1'b1;
        target = IRQ_VECTOR;
        st_nxt.in_irq = 1'b1;
        // Flag stays set for the handler; software clears it
      end
      else
      begin
        case (op_i)
          OP_SEQ: target = pc_inc;
          OP_GOTO: target = abs_target_i;
          OP_CALL:
          begin
            push = 1'b1;
            target = abs_target_i;
          end
          OP_COMPUTED_CALL:
          begin
            push = 1'b1;
            target = {latch_i, acc_i};
          end
          OP_ACC_REL: target = pc_inc + {7'h00, acc_i};
          OP_IMM_REL: target = pc_inc + {{7{operand_i[7]}}, operand_i};
          OP_RETURN, OP_RET_LIT: pop = 1'b1;
          OP_IRQ_EXIT:
          begin
            pop = 1'b1;
            st_nxt.restore = 1'b1;
            st_nxt.in_irq = 1'b0;
          end
          OP_NONE: target = st_r.pc;
          default: target = st_r.pc;
        endcase
      end
      // Return address goes into the slot after the top; index moves together
      if (push)
      begin
        wslot = idx_inc[3:0];
        stack_nxt[wslot] = pc_inc;
        st_nxt.idx = idx_inc;
        if (st_r.idx == TOP_IDX)
        begin
          st_nxt.ovf = 1'b1;
          st_nxt.fault_req = st_r.fault_rst_cfg;
          // Circular wrap to index 0 only when fault reset is off; else index steps on to 16
          st_nxt.idx = st_r.fault_rst_cfg ? idx_inc : {1'b0, idx_inc[3:0]};
        end
      end
      if (pop)
      begin
        target = stack_r[slot];
        st_nxt.idx = st_r.idx - ONE_IDX;
        if (st_r.idx == STACK_INDEX_RST)
        begin
          st_nxt.unf = 1'b1;
          st_nxt.fault_req = st_r.fault_rst_cfg;
          st_nxt.idx = st_r.fault_rst_cfg ? st_r.idx : {1'b0, 4'(st_r.idx - ONE_IDX)};
        end
      end
      st_nxt.pc = target;
      // AHB address phase capture
      st_nxt.dph = 1'b0;
      if (hsel && hready && htrans[1])
      begin
        st_nxt.dph = 1'b1;
        st_nxt.dwr = hwrite;
        st_nxt.daddr = haddr[7:0];
      end
      // Data phase write; software index write may race a push (caution)
      if (st_r.dph && st_r.dwr)
      begin
        case (st_r.daddr)
          OFS_STACK_INDEX: st_nxt.idx = hwdata[SP_W-1:0];
          OFS_STACK_TOP_LOW: stack_nxt[slot][7:0] = hwdata[7:0];
          OFS_STACK_TOP_HIGH: stack_nxt[slot][PC_W-1:8] = hwdata[6:0];
          OFS_STACK_FLAGS:
          begin
            st_nxt.ovf = (st_r.ovf & ~hwdata[FLAG_OVF_BIT]) | (push && st_r.idx == TOP_IDX);
            st_nxt.unf = (st_r.unf & ~hwdata[FLAG_UNF_BIT]) | (pop && st_r.idx == STACK_INDEX_RST);
          end
          OFS_CONFIG: st_nxt.fault_rst_cfg = hwdata[CFG_FAULT_RST_BIT];
          default: st_nxt.fault_rst_cfg = st_nxt.fault_rst_cfg;
        endcase
      end
      // Read data registered for the next data phase
      st_nxt.rdata = 32'h00000000;
      if (hsel && hready && htrans[1] && !hwrite)
      begin
        case (haddr[7:0])
          OFS_STACK_INDEX: st_nxt.rdata = {27'h0000000, st_nxt.idx};
          OFS_STACK_TOP_LOW: st_nxt.rdata = {24'h000000, stack_nxt[st_nxt.idx[3:0]][7:0]};
          OFS_STACK_TOP_HIGH: st_nxt.rdata = {25'h0000000, stack_nxt[st_nxt.idx[3:0]][14:8]};
          OFS_STACK_FLAGS: st_nxt.rdata = {30'h00000000, st_nxt.unf, st_nxt.ovf};
          OFS_CONFIG: st_nxt.rdata = {31'h00000000, st_nxt.fault_rst_cfg};
          default:
          begin
            if (haddr[7:0] >= OFS_SHADOW_ACC && haddr[7:0] <= OFS_SHADOW_LATCH)
              st_nxt.rdata = {24'h000000, shadow[8*(haddr[4:2])+:8]};
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= '0;
      st_r.pc <= PC_RST;
      st_r.idx <= STACK_INDEX_RST;
      st_r.fault_rst_cfg <= CFG_FAULT_RST_RST;
      stack_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      stack_r <= stack_nxt;
    end
  end

  // Outputs; latch is never driven by push or pop, only by restore
  assign pc_o = st_r.pc;
  assign irq_taken_o = irq_go;
  assign irq_flag_o = st_r.irq_flag;
  assign restore_o = st_r.restore;
  assign restore_acc_o = shadow[8*SH_ACC+:8];
  assign restore_status_o = shadow[8*SH_STATUS+:8];
  assign restore_bank_o = shadow[8*SH_BANK+:8];
  assign restore_ptr0_o = {shadow[8*SH_P0H+:8], shadow[8*SH_P0L+:8]};
  assign restore_ptr1_o = {shadow[8*SH_P1H+:8], shadow[8*SH_P1L+:8]};
  assign restore_latch_o = shadow[8*SH_LATCH+:7];
  assign stack_overrun_flag_o = st_r.ovf;
  assign stack_underrun_flag_o = st_r.unf;
  assign stack_fault_reset_o = st_r.fault_req;
  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  a_computed_call_target: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && op_i == OP_COMPUTED_CALL && !irq_go) |=> pc_o == {$past(latch_i), $past(acc_i)})
    else $error("computed call target wrong");
  a_acc_rel_sum: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && op_i == OP_ACC_REL && !irq_go)
    |=> pc_o == 15'($past(pc_o) + 15'h0001 + {7'h00, $past(acc_i)}))
    else $error("accumulator jump target wrong");
  a_imm_rel_sum: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && op_i == OP_IMM_REL && !irq_go) |=> pc_o == 15'($past(pc_o) + 15'h0001
    + {{7{$past(operand_i[7])}}, $past(operand_i)}))
    else $error("immediate jump target wrong");
  sequence s_call_then_ret;
    ce_i && op_i == OP_CALL && !irq_go && st_r.idx < TOP_IDX && !st_r.dph ##1
      ce_i && op_i == OP_RETURN && !irq_go && !st_r.dph;
  endsequence
  a_call_ret_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_call_then_ret |=> pc_o == 15'($past(pc_o, 2) + 15'h0001))
    else $error("return did not resume after call");
  a_push_index: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_go && st_r.idx != TOP_IDX && !st_r.dph) |=> st_r.idx == $past(st_r.idx) + ONE_IDX
    && pc_o == IRQ_VECTOR)
    else $error("entry index or vector wrong");
  a_overrun_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && (op_i == OP_CALL || op_i == OP_COMPUTED_CALL) && st_r.idx == TOP_IDX)
    |=> stack_overrun_flag_o)
    else $error("overrun not flagged");
  a_circular_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && op_i == OP_CALL && !irq_go && !st_r.fault_rst_cfg && st_r.idx == TOP_IDX
    && !st_r.dph) |=> st_r.idx == 5'h00 && stack_r[0] == $past(pc_inc))
    else $error("circular overwrite wrong");
  a_restore_pop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && op_i == OP_IRQ_EXIT && !irq_go) |=> restore_o ##1 !restore_o)
    else $error("restore strobe not single with pop");
  a_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pin_edge && ce_i) |=> irq_flag_o)
    else $error("edge did not set flag");
endmodule

/* design/pcsu_pkg.sv */
package pcsu_pkg;
  // Widths and stack depth
  localparam int PC_W = 15;
  localparam int SP_W = 5;
  localparam int STACK_DEPTH = 16;
  // Register offsets, byte addresses on the AHB-Lite slave
  localparam logic [7:0] OFS_STACK_INDEX = 8'h00;
  localparam logic [7:0] OFS_STACK_TOP_LOW = 8'h04;
  localparam logic [7:0] OFS_STACK_TOP_HIGH = 8'h08;
  localparam logic [7:0] OFS_STACK_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_CONFIG = 8'h10;
  localparam logic [7:0] OFS_SHADOW_ACC = 8'h20;
  localparam logic [7:0] OFS_SHADOW_STATUS = 8'h24;
  localparam logic [7:0] OFS_SHADOW_BANK = 8'h28;
  localparam logic [7:0] OFS_SHADOW_PTR0_LO = 8'h2C;
  localparam logic [7:0] OFS_SHADOW_PTR0_HI = 8'h30;
  localparam logic [7:0] OFS_SHADOW_PTR1_LO = 8'h34;
  localparam logic [7:0] OFS_SHADOW_PTR1_HI = 8'h38;
  localparam logic [7:0] OFS_SHADOW_LATCH = 8'h3C;
  // Field positions
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_UNF_BIT = 1;
  localparam int CFG_FAULT_RST_BIT = 0;
  localparam int STATUS_EXPIRY_BIT = 4;
  localparam int STATUS_SLEEP_BIT = 3;
  // Reset values and interrupt vector
  localparam logic [SP_W-1:0] STACK_INDEX_RST = 5'h1F;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 15'h0004;
  localparam logic CFG_FAULT_RST_RST = 1'b1;
  // Shadow slot numbers
  localparam int SH_ACC = 0;
  localparam int SH_STATUS = 1;
  localparam int SH_BANK = 2;
  localparam int SH_P0L = 3;
  localparam int SH_P0H = 4;
  localparam int SH_P1L = 5;
  localparam int SH_P1H = 6;
  localparam int SH_LATCH = 7;
  localparam int SH_COUNT = 8;
  // Flow operations from the decoder
  typedef enum logic [3:0]
  {
    OP_NONE = 4'h0,
    OP_SEQ = 4'h1,
    OP_CALL = 4'h2,
    OP_COMPUTED_CALL = 4'h3,
    OP_ACC_REL = 4'h4,
    OP_IMM_REL = 4'h5,
    OP_RETURN = 4'h6,
    OP_RET_LIT = 4'h7,
    OP_IRQ_EXIT = 4'h8,
    OP_GOTO = 4'h9
  } flow_op_type;
endpackage

/* design/shadow_bank.sv */
module shadow_bank
  import pcsu_pkg::*;
(
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic save_i, // Interrupt entry capture
  input wire logic [8*SH_COUNT-1:0] live_i, // Live core registers
  input wire logic sw_we_i, // Software write strobe
  input wire logic [2:0] sw_sel_i, // Software slot select
  input wire logic [7:0] sw_data_i, // Software write data
  output logic [8*SH_COUNT-1:0] copy_o // Shadow contents
);
  typedef struct packed
  {
    logic [SH_COUNT-1:0][7:0] slot;
  } shadow_state_type;

  shadow_state_type st_r;
  shadow_state_type st_nxt;

  // Entry capture wins over a software write in the same cycle
  always_comb
  begin
    st_nxt = st_r;
    if (ce_i && sw_we_i)
      st_nxt.slot[sw_sel_i] = sw_data_i;
    if (ce_i && save_i)
    begin
      st_nxt.slot = live_i;
      // Status expiry and sleep bits are never saved
      st_nxt.slot[SH_STATUS][STATUS_EXPIRY_BIT] = st_r.slot[SH_STATUS][STATUS_EXPIRY_BIT];
      st_nxt.slot[SH_STATUS][STATUS_SLEEP_BIT] = st_r.slot[SH_STATUS][STATUS_SLEEP_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign copy_o = st_r.slot;
endmodule

/* verification/core_model.sv */
module core_model
  import pcsu_pkg::*;
(
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic wr_i, // Core instruction writes registers
  input wire logic [62:0] wr_val_i, // Value written
  input wire logic restore_i, // Restore strobe from the unit
  input wire logic [62:0] restore_val_i, // Restored registers
  output logic [62:0] live_o // acc,status,bank,ptr0,ptr1,latch
);
  timeunit 1ns;
  timeprecision 1ps;

  // Restore beats a core write so that changes made in the handler are lost
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      live_o <= '0;
    else if (restore_i)
      live_o <= restore_val_i;
    else if (wr_i)
      live_o <= wr_val_i;
  end
endmodule

/* verification/testbench.sv */
module testbench
  import pcsu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, irq_pin, global_irq_enable, eie, fclr, hwrite, wr, hreadyout, hresp, ce;
  logic irq_taken, irq_flag, restore, ovf, unf, fault;
  flow_op_type op_i;
  logic [7:0] operand;
  logic [PC_W-1:0] target, pc;
  logic [31:0] haddr, hwdata, hrdata, tmp;
  logic [1:0] htrans;
  logic [62:0] wr_val, live, rv;
  int fail_count, n_compared;
  localparam logic [62:0] CV = {8'h21, 8'hFF, 8'h3F, 16'h1234, 16'h5678, 7'h35};

  pc_stack_context_unit pc_stack_context_unit_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .op_i(op_i), .operand_i(operand), .abs_target_i(target), .acc_i(live[62:55]),
    .status_i(live[54:47]), .bank_i(live[46:39]), .ptr0_i(live[38:23]),
    .ptr1_i(live[22:7]), .latch_i(live[6:0]), .irq_pin_i(irq_pin), .irq_rising_i(1'b1),
    .global_irq_enable_i(global_irq_enable), .ext_irq_enable_i(eie), .irq_flag_clr_i(fclr),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pc_o(pc), .irq_taken_o(irq_taken), .irq_flag_o(irq_flag), .restore_o(restore),
    .restore_acc_o(rv[62:55]), .restore_status_o(rv[54:47]), .restore_bank_o(rv[46:39]),
    .restore_ptr0_o(rv[38:23]), .restore_ptr1_o(rv[22:7]), .restore_latch_o(rv[6:0]),
    .stack_overrun_flag_o(ovf), .stack_underrun_flag_o(unf), .stack_fault_reset_o(fault));

  core_model core_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr), .wr_val_i(wr_val),
    .restore_i(restore), .restore_val_i(rv), .live_o(live));

  // Free-running core clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One single word transfer; the master waits on hready, never on a fixed count
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_i);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_i);
    while (hreadyout !== 1'b1) @(posedge clk_i);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_i);
    while (hreadyout !== 1'b1) @(posedge clk_i);
    rd = hrdata;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, tmp);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(a, 1'b0, 32'h00000000, tmp);
    chk_val(name, exp, tmp);
  endtask

  // One flow operation, then NONE so pc holds for the checks
  task automatic do_op(input flow_op_type o, input logic [7:0] opd, input logic [14:0] tg);
    @(posedge clk_i);
    op_i <= o;
    operand <= opd;
    target <= tg;
    @(posedge clk_i);
    op_i <= OP_NONE;
    #1;
  endtask

  task automatic set_core(input logic [62:0] v);
    @(posedge clk_i);
    wr <= 1'b1;
    wr_val <= v;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  // Watchdog: the tests need well under 2000 cycles
  initial
  begin
    #50000;
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    rst_n_i = 1'b0; op_i = OP_NONE; operand = 8'h00; target = 15'h0000; irq_pin = 1'b0;
    global_irq_enable = 1'b0; eie = 1'b0; fclr = 1'b0; haddr = 32'h00000000; htrans = 2'h0;
    hwrite = 1'b0; hwdata = 32'h00000000; wr = 1'b0; wr_val = '0; ce = 1'b1;
    fail_count = 0; n_compared = 0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk(OFS_STACK_INDEX, 32'h0000001F, "index");
    rd_chk(OFS_CONFIG, 32'h00000001, "config");
    rd_chk(OFS_STACK_FLAGS, 32'h00000000, "flags");
    rd_chk(8'h40, 32'h00000000, "unmapped");
    chk_val("hresp", 32'h00000000, {31'h00000000, hresp}); // Always OKAY
    set_core(CV);
    // Relative jumps, with carry and borrow across a page
    do_op(OP_GOTO, 8'h00, 15'h00F0);
    do_op(OP_ACC_REL, 8'h00, 15'h0000);
    chk_val("pc", 32'h00000112, {17'h00000, pc});
    do_op(OP_IMM_REL, 8'h80, 15'h0000);
    chk_val("pc", 32'h00000093, {17'h00000, pc});
    do_op(OP_IMM_REL, 8'h7F, 15'h0000);
    chk_val("pc", 32'h00000113, {17'h00000, pc});
    // Computed call and the pushed return address
    do_op(OP_COMPUTED_CALL, 8'h00, 15'h0000);
    chk_val("pc", 32'h00003521, {17'h00000, pc});
    chk_val("latch", 32'h00000035, {25'h0000000, live[6:0]});
    chk_val("restore", 32'h00000000, {31'h00000000, restore});
    rd_chk(OFS_STACK_INDEX, 32'h00000000, "index");
    rd_chk(OFS_STACK_TOP_LOW, 32'h00000014, "top_low");
    rd_chk(OFS_STACK_TOP_HIGH, 32'h00000001, "top_high");
    do_op(OP_RET_LIT, 8'h00, 15'h0000);
    chk_val("pc", 32'h00000114, {17'h00000, pc});
    rd_chk(OFS_STACK_INDEX, 32'h0000001F, "index");
    // Software places a return address through the top window
    wr_reg(OFS_STACK_INDEX, 32'h00000003);
    wr_reg(OFS_STACK_TOP_LOW, 32'h00000055);
    wr_reg(OFS_STACK_TOP_HIGH, 32'h00000012);
    rd_chk(OFS_STACK_TOP_LOW, 32'h00000055, "top_low");
    do_op(OP_RETURN, 8'h00, 15'h0000);
    chk_val("pc", 32'h00001255, {17'h00000, pc});
    // Call and return on back-to-back cycles
    @(posedge clk_i);
    op_i <= OP_CALL;
    target <= 15'h0400;
    @(posedge clk_i);
    op_i <= OP_RETURN;
    @(posedge clk_i);
    op_i <= OP_NONE;
    #1;
    chk_val("pc", 32'h00001256, {17'h00000, pc});
    rd_chk(OFS_STACK_INDEX, 32'h00000002, "index");
    // Clock enable low: the operation must be ignored
    ce <= 1'b0;
    do_op(OP_GOTO, 8'h00, 15'h7777);
    chk_val("pc_frozen", 32'h00001256, {17'h00000, pc}); // Enable low holds state
    ce <= 1'b1;
    // Overflow and underflow with fault reset enabled
    wr_reg(OFS_STACK_INDEX, 32'h0000000F);
    do_op(OP_CALL, 8'h00, 15'h0300);
    chk_val("fault", 32'h00000001, {31'h00000000, fault});
    chk_val("ovf", 32'h00000001, {31'h00000000, ovf});
    rd_chk(OFS_STACK_FLAGS, 32'h00000001, "flags");
    wr_reg(OFS_STACK_FLAGS, 32'h00000001);
    wr_reg(OFS_STACK_INDEX, 32'h0000001F);
    do_op(OP_RETURN, 8'h00, 15'h0000);
    chk_val("unf", 32'h00000001, {31'h00000000, unf});
    rd_chk(OFS_STACK_FLAGS, 32'h00000002, "flags");
    wr_reg(OFS_STACK_FLAGS, 32'h00000002);
    // Circular mode: the seventeenth push lands on the first entry
    wr_reg(OFS_CONFIG, 32'h00000000);
    do_op(OP_GOTO, 8'h00, 15'h0200);
    for (int i = 0; i < 17; i++)
      do_op(OP_CALL, 8'h00, 15'(32'h100 + i));
    rd_chk(OFS_STACK_FLAGS, 32'h00000001, "flags");
    do_op(OP_RETURN, 8'h00, 15'h0000);
    chk_val("pc", 32'h00000110, {17'h00000, pc});
    do_op(OP_RETURN, 8'h00, 15'h0000);
    chk_val("pc", 32'h0000010F, {17'h00000, pc});
    wr_reg(OFS_CONFIG, 32'h00000001);
    wr_reg(OFS_STACK_FLAGS, 32'h00000003);
    // Interrupt entry; index is set before enables go high, never after
    wr_reg(OFS_STACK_INDEX, 32'h0000001F);
    @(posedge clk_i);
    global_irq_enable <= 1'b1;
    eie <= 1'b1;
    irq_pin <= 1'b1;
    repeat (20)
    begin
      @(posedge clk_i);
      if (irq_taken === 1'b1)
        break;
    end
    #1;
    chk_val("pc", 32'h00000004, {17'h00000, pc});
    chk_val("irq_flag", 32'h00000001, {31'h00000000, irq_flag});
    chk_val("irq_taken", 32'h00000000, {31'h00000000, irq_taken});
    rd_chk(OFS_STACK_INDEX, 32'h00000000, "index");
    rd_chk(OFS_SHADOW_ACC, 32'h00000021, "sh_acc");
    rd_chk(OFS_SHADOW_PTR1_HI, 32'h00000056, "sh_p1h");
    rd_chk(OFS_SHADOW_STATUS, 32'h000000E7, "sh_status");
    // Handler changes live registers and edits one shadow
    set_core('0);
    wr_reg(OFS_SHADOW_BANK, 32'h0000005A);
    @(posedge clk_i);
    fclr <= 1'b1;
    @(posedge clk_i);
    fclr <= 1'b0;
    do_op(OP_IRQ_EXIT, 8'h00, 15'h0000);
    chk_val("pc", 32'h00000110, {17'h00000, pc});
    chk_val("restore", 32'h00000001, {31'h00000000, restore});
    chk_val("irq_flag", 32'h00000000, {31'h00000000, irq_flag});
    @(posedge clk_i);
    #1;
    chk_val("acc", 32'h00000021, {24'h000000, live[62:55]});
    chk_val("status", 32'h000000E7, {24'h000000, live[54:47]});
    chk_val("bank", 32'h0000005A, {24'h000000, live[46:39]});
    chk_val("ptr0", 32'h00001234, {16'h0000, live[38:23]});
    chk_val("latch", 32'h00000035, {25'h0000000, live[6:0]});
    rd_chk(OFS_STACK_INDEX, 32'h0000001F, "index");
    tally_and_finish();
  end
endmodule
